// ==== rtl/frs_pkg.sv ====
// Shared constants and types for the FIFO reset sequencer
package frs_pkg;
   // Consecutive reset-match samples before a FIFO reset is recognized
   localparam logic [3:0] FRS_RST_MATCH_CYCLES = 4'h8;
   // Writes still accepted after an ordinary FULL
   localparam logic [2:0] FRS_POST_FULL_WRITES = 3'h4;
   // Synchroniser vector width and bit positions of each pin
   localparam int FRS_SYNC_W = 7;
   localparam int FRS_BIT_CE = 0;
   localparam int FRS_BIT_CLK = 1;
   localparam int FRS_BIT_REQ = 3;
   localparam int FRS_BIT_EN = 5;
   // Direction indices
   localparam int FRS_DIR_TX = 0;
   localparam int FRS_DIR_RX = 1;
   // Reset values
   localparam logic [FRS_SYNC_W-1:0] FRS_SYNC_RST = 7'h7F;
   localparam logic FRS_FLAG_IDLE_N = 1'h1;

   typedef enum logic [1:0] {
      FRS_ST_IDLE,
      FRS_ST_FORCED,
      FRS_ST_CLEAR
   } frs_seq_state_t;
endpackage

// ==== rtl/frs_seq.sv ====
// Per-direction FIFO reset sequencer: match tracking and cycle count
`timescale 1ns/10ps
module frs_seq
   import frs_pkg::*;
(
   input wire logic clock_i,
   input wire logic rstn_i,
   frs_seq_if.seq bus
);
   typedef struct packed {
      frs_seq_state_t state;
      logic [3:0] cnt;
      logic drive;
      logic rmatch;
   } frs_seq_reg_t;

   frs_seq_reg_t s_q;
   frs_seq_reg_t s_d;

   // Next state, evaluated on a sampling edge of the pin clock; CLEAR returns to IDLE on the next cycle regardless
   always_comb begin
      logic rm;
      logic ok;
      logic [3:0] cnt_inc;
      rm = 1'b0;
      ok = 1'b0;
      cnt_inc = 4'h0;
      s_d = s_q;
      if (bus.sample) begin
         rm = !bus.ce_n && !bus.req_n;
         // Drivers on for normal match or reset match
         s_d.drive = !bus.ce_n;
         s_d.rmatch = rm;
         // Enable asserted inhibits and clears the count
         ok = rm && bus.en_n;
         cnt_inc = s_q.cnt + 4'h1;
      end
      case (s_q.state)
         FRS_ST_IDLE: begin
            if (bus.sample) begin
               if (ok) begin
                  // Count only consecutive matched edges
                  s_d.cnt = cnt_inc;
                  if (cnt_inc == FRS_RST_MATCH_CYCLES) begin
                     s_d.state = FRS_ST_FORCED;
                     s_d.cnt = 4'h0;
                  end
               end else begin
                  // Broken sequence leaves the FIFO untouched
                  s_d.cnt = 4'h0;
               end
            end
         end
         FRS_ST_FORCED: begin
            // Hold until host removes select or request
            if (bus.sample && !rm) begin
               s_d.state = FRS_ST_CLEAR;
            end
         end
         FRS_ST_CLEAR: begin
            s_d.state = FRS_ST_IDLE;
            s_d.cnt = 4'h0;
         end
         default: begin
            s_d.state = FRS_ST_IDLE;
         end
      endcase
   end

   // Starts in CLEAR so both FIFOs are flushed at power-up
   always_ff @(posedge clock_i or negedge rstn_i) begin
      if (!rstn_i) begin
         s_q <= '{FRS_ST_CLEAR, 4'h0, 1'b0, 1'b0};
      end else begin
         s_q <= s_d;
      end
   end

   assign bus.drive = s_q.drive;
   assign bus.rst_match = s_q.rmatch;
   assign bus.forced = (s_q.state == FRS_ST_FORCED);
   assign bus.clear = (s_q.state == FRS_ST_CLEAR);
endmodule

// ==== rtl/frs_seq_if.sv ====
// Link between the pin sampler and one direction's reset sequencer
`timescale 1ns/10ps
interface frs_seq_if;
   logic sample;
   logic ce_n;
   logic req_n;
   logic en_n;
   logic drive;
   logic rst_match;
   logic forced;
   logic clear;
   modport ctl(output sample, ce_n, req_n, en_n,
               input drive, rst_match, forced, clear);
   modport seq(input sample, ce_n, req_n, en_n,
               output drive, rst_match, forced, clear);
endinterface

// ==== rtl/frs_top.sv ====
// FIFO reset sequencer top: pin sampling, both directions, flag drivers
`timescale 1ns/10ps
// What this block does
// - Start transmit reset when request and select both sample low
// - Drive transmit flags while the transmit reset match holds
// - After eight matched cycles force transmit FULL on the flags
// - Asserted write enable holds off the reset until removed
// - After ordinary FULL, accept up to four more writes
// - Reset-forced FULL rejects every further write
// - Reset only finishes after host removes request or select
// - Select raised ends reset and floats the transmit flags
// - Request raised with select low becomes normal match, flags driven
// - Reset completion shows EMPTY: empty asserted, half and full not
// - Write enable with select low clears the reset counter
// - Flags are active low; blocked reset leaves full flag high
// - Receive reset uses same conditions on receive clock and enable
// - Recognized receive reset forces receive flags to EMPTY
// - Receive reset gives no separate completion indication
// - Disrupted sequence before eight cycles leaves the FIFO unreset
// - Both FIFOs are cleared automatically at power-up
// - No match of either kind floats that direction's flags
module frs_top
   import frs_pkg::*;
(
   input wire logic clock_i,
   input wire logic rstn_i,
   input wire logic ce_n_i,
   input wire logic tx_iface_clock_i,
   input wire logic rx_iface_clock_i,
   input wire logic tx_fifo_reset_req_n_i,
   input wire logic rx_fifo_reset_req_n_i,
   input wire logic tx_write_enable_n_i,
   input wire logic rx_read_enable_n_i,
   input wire logic tx_fifo_empty_i,
   input wire logic tx_fifo_half_i,
   input wire logic tx_fifo_full_i,
   input wire logic tx_fifo_write_i,
   input wire logic rx_fifo_empty_i,
   input wire logic rx_fifo_full_i,
   output logic tx_fifo_clear_o,
   output logic rx_fifo_clear_o,
   output logic tx_write_allow_o,
   output logic tx_reset_match_o,
   output logic rx_reset_match_o,
   output logic tx_empty_flag_n_o,
   output logic tx_empty_flag_n_oe_o,
   output logic tx_half_flag_n_o,
   output logic tx_full_flag_n_o,
   output logic tx_full_flag_n_oe_o,
   output logic rx_empty_flag_n_o,
   output logic rx_empty_flag_n_oe_o,
   output logic rx_full_flag_n_o,
   output logic rx_full_flag_n_oe_o
);
   typedef struct packed {
      logic [FRS_SYNC_W-1:0] sync1;
      logic [FRS_SYNC_W-1:0] sync2;
      logic [1:0] clk_prev;
      logic [2:0] extra;
      logic tx_e_n;
      logic tx_h_n;
      logic tx_f_n;
      logic tx_oe;
      logic rx_e_n;
      logic rx_f_n;
      logic rx_oe;
   } frs_top_reg_t;

   frs_top_reg_t s_q;
   frs_top_reg_t s_d;

   logic [FRS_SYNC_W-1:0] pins;
   logic [1:0] rise;
   logic [1:0] drive_w;
   logic [1:0] rmatch_w;
   logic [1:0] forced_w;
   logic [1:0] clear_w;

   // Active-high status to active-low flag, forced or passed through
   function automatic logic flag_n(input logic forced_val,
                                   input logic forced,
                                   input logic status);
      flag_n = forced ? forced_val : !status;
   endfunction

   // All pins gathered for the two-stage synchroniser
   assign pins = {rx_read_enable_n_i, tx_write_enable_n_i,
                  rx_fifo_reset_req_n_i, tx_fifo_reset_req_n_i,
                  rx_iface_clock_i, tx_iface_clock_i, ce_n_i};

   // Pin clocks must stay well below a quarter of clock_i
   assign rise = s_q.sync2[FRS_BIT_CLK +: 2] & ~s_q.clk_prev;

   // One sequencer per direction, joined by its own interface
   genvar gi;
   generate
      for (gi = 0; gi < 2; gi++) begin : g_dir
         frs_seq_if sif();
         assign sif.sample = rise[gi];
         assign sif.ce_n = s_q.sync2[FRS_BIT_CE];
         assign sif.req_n = s_q.sync2[FRS_BIT_REQ + gi];
         assign sif.en_n = s_q.sync2[FRS_BIT_EN + gi];
         assign drive_w[gi] = sif.drive;
         assign rmatch_w[gi] = sif.rst_match;
         assign forced_w[gi] = sif.forced;
         assign clear_w[gi] = sif.clear;
         frs_seq u_seq (
            .clock_i(clock_i),
            .rstn_i(rstn_i),
            .bus(sif.seq)
         );
      end
   endgenerate

   // Next state for synchroniser, write budget and flag registers
   always_comb begin
      s_d = s_q;
      s_d.sync1 = pins;
      s_d.sync2 = s_q.sync1;
      s_d.clk_prev = s_q.sync2[FRS_BIT_CLK +: 2];
      // Extra writes past an ordinary FULL are counted
      if (!tx_fifo_full_i || clear_w[FRS_DIR_TX]) begin
         s_d.extra = 3'h0;
      end else if (tx_fifo_write_i && s_q.extra < FRS_POST_FULL_WRITES) begin
         s_d.extra = s_q.extra + 3'h1;
      end
      // Forced FULL on transmit: empty high, half and full low
      s_d.tx_e_n = flag_n(1'b1, forced_w[FRS_DIR_TX],
                          tx_fifo_empty_i);
      s_d.tx_h_n = flag_n(1'b0, forced_w[FRS_DIR_TX], tx_fifo_half_i);
      s_d.tx_f_n = flag_n(1'b0, forced_w[FRS_DIR_TX], tx_fifo_full_i);
      // Forced EMPTY on receive stops further reads
      s_d.rx_e_n = flag_n(1'b0, forced_w[FRS_DIR_RX],
                          rx_fifo_empty_i);
      s_d.rx_f_n = flag_n(1'b1, forced_w[FRS_DIR_RX], rx_fifo_full_i);
      // Drivers float outside any match
      s_d.tx_oe = drive_w[FRS_DIR_TX];
      s_d.rx_oe = drive_w[FRS_DIR_RX];
   end

   // Flags reset high and floating; drivers stay off until the first match
   always_ff @(posedge clock_i or negedge rstn_i) begin
      if (!rstn_i) begin
         s_q <= '{FRS_SYNC_RST, FRS_SYNC_RST, 2'h3, 3'h0,
                  FRS_FLAG_IDLE_N, FRS_FLAG_IDLE_N, FRS_FLAG_IDLE_N, 1'b0,
                  FRS_FLAG_IDLE_N, FRS_FLAG_IDLE_N, 1'b0};
      end else begin
         s_q <= s_d;
      end
   end

   // Forced FULL shuts the write path entirely
   assign tx_write_allow_o = !forced_w[FRS_DIR_TX] &&
      (!tx_fifo_full_i || s_q.extra < FRS_POST_FULL_WRITES);
   assign tx_fifo_clear_o = clear_w[FRS_DIR_TX];
   assign rx_fifo_clear_o = clear_w[FRS_DIR_RX];
   assign tx_reset_match_o = rmatch_w[FRS_DIR_TX];
   assign rx_reset_match_o = rmatch_w[FRS_DIR_RX];
   assign tx_empty_flag_n_o = s_q.tx_e_n;
   assign tx_half_flag_n_o = s_q.tx_h_n;
   assign tx_full_flag_n_o = s_q.tx_f_n;
   assign tx_empty_flag_n_oe_o = s_q.tx_oe;
   assign tx_full_flag_n_oe_o = s_q.tx_oe;
   assign rx_empty_flag_n_o = s_q.rx_e_n;
   assign rx_full_flag_n_o = s_q.rx_f_n;
   assign rx_empty_flag_n_oe_o = s_q.rx_oe;
   assign rx_full_flag_n_oe_o = s_q.rx_oe;
endmodule

// ==== tb/frs_host_model.sv ====
// Host-side model: pin clocks plus select, request and enable pins
`timescale 1ns/10ps
module frs_host_model (
   input wire logic clock_i,
   output logic tx_iface_clock_i,
   output logic rx_iface_clock_i,
   output logic ce_n_i,
   output logic tx_fifo_reset_req_n_i,
   output logic rx_fifo_reset_req_n_i,
   output logic tx_write_enable_n_i,
   output logic rx_read_enable_n_i
);
   int tick = 0;
   // Idle pins from time zero, so no unknown reaches the flag enables
   initial begin
      {tx_iface_clock_i, rx_iface_clock_i} = 2'h0;
      {ce_n_i, tx_fifo_reset_req_n_i, rx_fifo_reset_req_n_i,
       tx_write_enable_n_i, rx_read_enable_n_i} = 5'h1F;
   end
   // Free-running pin clocks, 16 and 12 system cycles, unrelated phase
   always @(negedge clock_i) begin
      tick <= tick + 1;
      tx_iface_clock_i <= tick[3];
      rx_iface_clock_i <= (tick % 12) < 6;
   end
   // Pins move on a falling transmit pin clock, clear of its sampling edges
   task automatic pins(input logic [4:0] v);
      @(negedge tx_iface_clock_i);
      {ce_n_i, tx_fifo_reset_req_n_i, rx_fifo_reset_req_n_i,
       tx_write_enable_n_i, rx_read_enable_n_i} = v;
   endtask
endmodule

// ==== tb/frs_top_props.sv ====
// Concurrent checks on the FIFO reset sequencer ports
`timescale 1ns/10ps
module frs_top_props (
   input wire logic clock_i,
   rstn_i,
   tx_fifo_full_i,
   rx_fifo_empty_i,
   tx_fifo_clear_o,
   rx_fifo_clear_o,
   tx_write_allow_o,
   tx_reset_match_o,
   rx_reset_match_o,
   tx_full_flag_n_o,
   tx_empty_flag_n_oe_o,
   tx_full_flag_n_oe_o,
   rx_empty_flag_n_o,
   rx_empty_flag_n_oe_o,
   rx_full_flag_n_oe_o
);
   default clocking cb @(posedge clock_i); endclocking
   default disable iff (!rstn_i);
   // Clears are single pulses; a clear leaves writes open
   tx_clear_pulse_a: assert property (
      tx_fifo_clear_o |=> !tx_fifo_clear_o)
      else $error("tx clear longer than one cycle");
   rx_clear_pulse_a: assert property (
      rx_fifo_clear_o |=> !rx_fifo_clear_o)
      else $error("rx clear longer than one cycle");
   clear_allow_a: assert property (
      tx_fifo_clear_o |=> tx_write_allow_o)
      else $error("writes still refused after clear");
   // Both drivers of a direction switch together
   tx_oe_pair_a: assert property (
      tx_empty_flag_n_oe_o == tx_full_flag_n_oe_o)
      else $error("tx flag enables differ");
   rx_oe_pair_a: assert property (
      rx_empty_flag_n_oe_o == rx_full_flag_n_oe_o)
      else $error("rx flag enables differ");
   tx_match_drive_a: assert property (
      tx_reset_match_o |=> tx_full_flag_n_oe_o)
      else $error("tx flags not driven during reset match");
   rx_match_drive_a: assert property (
      rx_reset_match_o |=> rx_full_flag_n_oe_o)
      else $error("rx flags not driven during reset match");
   // A forced flag needs a reset match now and eight clock cycles earlier
   tx_forced_cause_a: assert property (
      $fell(tx_full_flag_n_o) && !tx_fifo_full_i &&
      !$past(tx_fifo_full_i)
      |-> tx_reset_match_o && $past(tx_reset_match_o, 8))
      else $error("tx full forced without reset match");
   rx_forced_cause_a: assert property (
      $fell(rx_empty_flag_n_o) && !rx_fifo_empty_i &&
      !$past(rx_fifo_empty_i)
      |-> rx_reset_match_o && $past(rx_reset_match_o, 8))
      else $error("rx empty forced without reset match");
   cover property ($fell(tx_full_flag_n_o) && tx_reset_match_o);
   cover property ($fell(rx_empty_flag_n_o) && rx_reset_match_o);
   cover property (!tx_write_allow_o && !tx_reset_match_o);
endmodule

bind frs_top frs_top_props frs_top_props_inst (.*);

// ==== tb/test_frs_top.sv ====
// Self-checking bench for the FIFO reset sequencer
`timescale 1ns/10ps
module test_frs_top;
   import frs_pkg::*;
   logic clock_i, rstn_i, tx_fifo_empty_i, tx_fifo_half_i, tx_fifo_full_i;
   logic tx_fifo_write_i, rx_fifo_empty_i, rx_fifo_full_i, ce_n_i;
   logic tx_iface_clock_i, rx_iface_clock_i, tx_fifo_reset_req_n_i;
   logic rx_fifo_reset_req_n_i, tx_write_enable_n_i, rx_read_enable_n_i;
   logic tx_fifo_clear_o, rx_fifo_clear_o, tx_write_allow_o;
   logic tx_reset_match_o, rx_reset_match_o, tx_empty_flag_n_o;
   logic tx_empty_flag_n_oe_o, tx_half_flag_n_o, tx_full_flag_n_o;
   logic tx_full_flag_n_oe_o, rx_empty_flag_n_o, rx_empty_flag_n_oe_o;
   logic rx_full_flag_n_o, rx_full_flag_n_oe_o;
   logic [4:0] abort_v [3] = '{5'h0F, 5'h05, 5'h1F};
   int fail_count = 0;
   int cmp_count = 0;
   int seed = 32'h724D076F;
   int tx_clears = 0;
   int rx_clears = 0;
   int clr_base = 0;
   frs_top frs_top_inst (.*);
   frs_host_model frs_host_model_inst (.*);
   initial begin
      clock_i = 1'h0;
      forever #10 clock_i = ~clock_i;
   end
   // Clear pulses stand a whole cycle, so each falling edge sees one once
   always @(negedge clock_i) begin
      if (tx_fifo_clear_o) tx_clears++;
      if (rx_fifo_clear_o) rx_clears++;
   end
   task automatic check(input logic [3:0] seen, input logic [3:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         fail_count++;
         $display("MISMATCH %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic report_and_stop();
      if (fail_count == 0 && cmp_count > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask
   // Set pins {ce, tx req, rx req, tx en, rx en}, then wait pin periods
   task automatic go(input logic [4:0] v, input int n);
      frs_host_model_inst.pins(v);
      repeat (n) @(negedge tx_iface_clock_i);
   endtask
   function automatic logic [3:0] txv();
      return {tx_empty_flag_n_o, tx_half_flag_n_o, tx_full_flag_n_o,
              tx_full_flag_n_oe_o};
   endfunction
   // Forced states are fixed; otherwise the flags mirror FIFO status
   function automatic logic [3:0] tx_exp(input logic f);
      return f ? 4'h9 : {~tx_fifo_empty_i, ~tx_fifo_half_i,
                         ~tx_fifo_full_i, 1'h1};
   endfunction
   function automatic logic [3:0] rx_exp(input logic f);
      return f ? 4'h1 : {2'h0, ~rx_fifo_empty_i, ~rx_fifo_full_i};
   endfunction
   // Hang guard, far beyond the longest sequence
   initial begin
      #1000000;
      fail_count++;
      report_and_stop();
   end
   initial begin
      rstn_i = 1'h0;
      tx_fifo_write_i = 1'h0;
      {tx_fifo_empty_i, tx_fifo_half_i, tx_fifo_full_i} = 3'h4;
      {rx_fifo_empty_i, rx_fifo_full_i} = 2'h0;
      repeat (4) @(negedge clock_i);
      check(4'({tx_fifo_clear_o, rx_fifo_clear_o}), 4'h3);
      rstn_i = 1'h1;
      go(5'h1F, 2);
      check(4'({tx_full_flag_n_oe_o, rx_full_flag_n_oe_o}),
            4'h0);
      // Full reset, then release by request or by select
      for (int k = 0; k < 4; k++) begin
         tx_fifo_empty_i = 1'($random(seed));
         tx_fifo_half_i = 1'($random(seed));
         clr_base = tx_clears;
         go(5'h07, 10);
         check(txv(), tx_exp(1'h1));
         check(4'({tx_write_allow_o, tx_reset_match_o}), 4'h1);
         go(k[0] ? 5'h1F : 5'h0F, 3);
         if (k[0]) begin
            check(4'(tx_full_flag_n_oe_o), 4'h0);
            go(5'h0F, 3);
         end
         check(txv(), tx_exp(1'h0));
         check(4'(tx_clears - clr_base), 4'h1);
      end
      // Held enable blocks the count until it goes away
      go(5'h05, 12);
      check(txv(), tx_exp(1'h0));
      go(5'h07, 10);
      check(txv(), tx_exp(1'h1));
      // Each kind of break restarts the count from zero
      foreach (abort_v[i]) begin
         go(5'h0F, 2);
         go(5'h07, 5);
         go(abort_v[i], 1);
         go(5'h07, 5);
         check(txv(), tx_exp(1'h0));
      end
      go(5'h0F, 3);
      // Ordinary full still takes four writes, the fifth is refused
      tx_fifo_full_i = 1'h1;
      for (int i = 1; i <= 5; i++) begin
         @(negedge clock_i) tx_fifo_write_i = 1'h1;
         @(negedge clock_i) tx_fifo_write_i = 1'h0;
         check(4'(tx_write_allow_o), 4'(i < 4));
      end
      tx_fifo_full_i = 1'h0;
      clr_base = rx_clears;
      // Receive reset forces EMPTY unless its enable is held
      for (int k = 0; k < 2; k++) begin
         rx_fifo_full_i = 1'($random(seed));
         go(5'h1F, 2);
         go(k ? 5'h0A : 5'h0B, 12);
         check(4'({rx_empty_flag_n_o, rx_full_flag_n_o}),
               rx_exp(k == 0));
      end
      // Only the unblocked receive reset may clear the FIFO
      check(4'(rx_clears - clr_base), 4'h1);
      go(5'h1F, 2);
      report_and_stop();
   end
endmodule
